// File: ppfm_map.vh
`ifndef PPFM_MAP_VH
`define PPFM_MAP_VH
`define PPFM_PA_W 6
`define PPFM_PB_W 4
`define PPFM_PB_LO 4
`define PPFM_SEL_W 2
`define PPFM_SEL_GPIO 2'h0
`define PPFM_SEL_ALT1 2'h1
`define PPFM_SEL_ALT2 2'h2
`define PPFM_SEL_ALT3 2'h3
`define PPFM_PB_TCK 0
`define PPFM_PB_TDI 1
`define PPFM_PB_TMS 2
`define PPFM_PB_TDO 3
`define PPFM_TAP_EN_RST 1'h1
`define PPFM_DIR_RST 1'h0
`define PPFM_OUT_RST 1'h0
`endif

// File: ppfm_sync.v
`timescale 1ns/1ps
`default_nettype none
module ppfm_sync (
    input wire clk,
    input wire rst,
    input wire d,
    output reg q
);
    reg s1_r;
    reg s2_r;
    reg s3_r;
    always @(posedge clk) begin
        if (rst) begin
            s1_r <= 1'b0;
            s2_r <= 1'b0;
            s3_r <= 1'b0;
            q <= 1'b0;
        end else begin
            s1_r <= d;
            s2_r <= s1_r;
            s3_r <= s2_r;
            if (s2_r == s3_r) begin
                q <= s3_r;
            end
        end
    end
endmodule
`default_nettype wire

// File: ppfm_pin.v
`timescale 1ns/1ps
`default_nettype none
module ppfm_pin (
    input wire clk,
    input wire rst,
    input wire alt_en,
    input wire alt_out,
    input wire alt_oe,
    input wire gp_dir,
    input wire gp_out,
    input wire pu_en,
    input wire pad_in,
    output reg pad_out,
    output reg pad_oe,
    output reg pad_pu,
    output wire pin_level
);
    reg out_nxt;
    reg oe_nxt;
    ppfm_sync u_sync (
        .clk(clk),
        .rst(rst),
        .d(pad_in),
        .q(pin_level)
    );
    always @* begin
        out_nxt = gp_out;
        oe_nxt = gp_dir;
        if (alt_en) begin
            out_nxt = alt_out;
            oe_nxt = alt_oe;
        end
    end
    always @(posedge clk) begin
        if (rst) begin
            pad_out <= 1'b0;
            pad_oe <= 1'b0;
            pad_pu <= pu_en;
        end else begin
            pad_out <= out_nxt;
            pad_oe <= oe_nxt;
            pad_pu <= pu_en;
        end
    end
endmodule
`default_nettype wire

// File: ppfm_top.v
`timescale 1ns/1ps
`default_nettype none
`include "ppfm_map.vh"
module ppfm_top (
    input wire SYS_CLK,
    input wire RST,
    input wire [5:0] PORT_A_DIRECTION,
    input wire [5:0] PORT_A_OUTPUT,
    output reg [5:0] PORT_A_INPUT,
    input wire [11:0] PORT_A_SEL,
    input wire [3:0] PORT_B_DIRECTION,
    input wire [3:0] PORT_B_OUTPUT,
    output reg [3:0] PORT_B_INPUT,
    input wire TAP_ENABLE_WR,
    input wire TAP_ENABLE_VAL,
    output wire SYSTEM_CONTROL_TAP,
    input wire TWOWIRE_B_EN,
    input wire [5:0] PA_PAD_IN,
    output wire [5:0] PA_PAD_OUT,
    output wire [5:0] PA_PAD_OE,
    input wire [3:0] PB_PAD_IN,
    output wire [3:0] PB_PAD_OUT,
    output wire [3:0] PB_PAD_OE,
    output wire [3:0] PB_PAD_PU,
    output wire SERIAL_RECEIVE_LINE,
    input wire SERIAL_TRANSMIT_LINE,
    input wire SPI_MISO_OUT,
    input wire SPI_MISO_OE,
    output wire SPI_MOSI_IN,
    output wire SPI_SCLK_IN,
    output wire SPI_SSEL_IN,
    input wire TWOWIRE_A_CLOCK_LOW,
    input wire TWOWIRE_A_DATA_LOW,
    output wire TWOWIRE_A_CLOCK,
    output wire TWOWIRE_A_DATA,
    input wire TWOWIRE_B_CLOCK_LOW,
    input wire TWOWIRE_B_DATA_LOW,
    output wire TWOWIRE_B_CLOCK,
    output wire TWOWIRE_B_DATA,
    input wire TIMER_B_CHANNEL_A_OUT,
    input wire TIMER_B_CHANNEL_A_OE,
    output wire TIMER_B_CHANNEL_A_IN,
    input wire TIMER_B_CHANNEL_B_OUT,
    input wire TIMER_B_CHANNEL_B_OE,
    output wire TIMER_B_CHANNEL_B_IN,
    output wire [5:0] EXT_IRQ_LINES,
    output wire TAP_TCK,
    output wire TAP_TDI,
    output wire TAP_TMS,
    input wire TAP_TDO,
    input wire TAP_SHIFT_IR,
    input wire TAP_SHIFT_DR
);
    reg tap_en_r;
    reg [5:0] a_alt_en;
    reg [5:0] a_alt_out;
    reg [5:0] a_alt_oe;
    reg [3:0] b_alt_en;
    reg [3:0] b_alt_out;
    reg [3:0] b_alt_oe;
    reg [3:0] b_pu;
    wire [5:0] a_lvl;
    wire [3:0] b_lvl;
    wire [1:0] s0 = PORT_A_SEL[1:0];
    wire [1:0] s1 = PORT_A_SEL[3:2];
    wire [1:0] s2 = PORT_A_SEL[5:4];
    wire [1:0] s3 = PORT_A_SEL[7:6];
    wire [1:0] s4 = PORT_A_SEL[9:8];
    wire [1:0] s5 = PORT_A_SEL[11:10];
    wire tap_shift = TAP_SHIFT_IR | TAP_SHIFT_DR;
    wire tw_b = ~tap_en_r & TWOWIRE_B_EN;

    always @(posedge SYS_CLK) begin
        if (RST) begin
            tap_en_r <= `PPFM_TAP_EN_RST;
        end else if (TAP_ENABLE_WR) begin
            tap_en_r <= TAP_ENABLE_VAL;
        end
    end
    assign SYSTEM_CONTROL_TAP = tap_en_r;

    // Port A alternate steering; select 0 keeps general I/O
    always @* begin
        a_alt_en = 6'h00;
        a_alt_out = 6'h00;
        a_alt_oe = 6'h00;
        // Pin 0: receive and MOSI are inputs only
        a_alt_en[0] = (s0 != `PPFM_SEL_GPIO);
        // Pin 1: transmit or MISO drive
        a_alt_en[1] = (s1 != `PPFM_SEL_GPIO);
        if (s1 == `PPFM_SEL_ALT1) begin
            a_alt_out[1] = SERIAL_TRANSMIT_LINE;
            a_alt_oe[1] = 1'b1;
        end else if (s1 == `PPFM_SEL_ALT2) begin
            a_alt_out[1] = SPI_MISO_OUT;
            a_alt_oe[1] = SPI_MISO_OE;
        end
        // Pin 2 and 3: two-wire open drain
        a_alt_en[2] = (s2 != `PPFM_SEL_GPIO);
        if (s2 == `PPFM_SEL_ALT1) begin
            a_alt_oe[2] = TWOWIRE_A_CLOCK_LOW;
        end
        a_alt_en[3] = (s3 != `PPFM_SEL_GPIO);
        if (s3 == `PPFM_SEL_ALT1) begin
            a_alt_oe[3] = TWOWIRE_A_DATA_LOW;
        end
        // Pin 4 and 5: timer B channels
        a_alt_en[4] = (s4 != `PPFM_SEL_GPIO);
        if (s4 == `PPFM_SEL_ALT1) begin
            a_alt_out[4] = TIMER_B_CHANNEL_A_OUT;
            a_alt_oe[4] = TIMER_B_CHANNEL_A_OE;
        end
        a_alt_en[5] = (s5 != `PPFM_SEL_GPIO);
        if (s5 == `PPFM_SEL_ALT1) begin
            a_alt_out[5] = TIMER_B_CHANNEL_B_OUT;
            a_alt_oe[5] = TIMER_B_CHANNEL_B_OE;
        end
    end

    // Port B: test port first, then two-wire B, then general I/O
    always @* begin
        b_alt_en = 4'h0;
        b_alt_out = 4'h0;
        b_alt_oe = 4'h0;
        b_pu = 4'h0;
        if (tap_en_r | RST) begin
            b_alt_en = 4'hf;
            b_pu = 4'hf;
            b_alt_out[`PPFM_PB_TDO] = TAP_TDO;
            b_alt_oe[`PPFM_PB_TDO] = tap_shift;
        end else if (tw_b) begin
            b_alt_en[`PPFM_PB_TCK] = 1'b1;
            b_alt_en[`PPFM_PB_TDI] = 1'b1;
            b_alt_oe[`PPFM_PB_TCK] = TWOWIRE_B_CLOCK_LOW;
            b_alt_oe[`PPFM_PB_TDI] = TWOWIRE_B_DATA_LOW;
        end
    end

    // Registered pad drive avoids glitches on mode change
    ppfm_pin u_pa0 (
        .clk(SYS_CLK), .rst(RST),
        .alt_en(a_alt_en[0]),
        .alt_out(a_alt_out[0]),
        .alt_oe(a_alt_oe[0]),
        .gp_dir(PORT_A_DIRECTION[0]),
        .gp_out(PORT_A_OUTPUT[0]),
        .pu_en(1'b0),
        .pad_in(PA_PAD_IN[0]),
        .pad_out(PA_PAD_OUT[0]),
        .pad_oe(PA_PAD_OE[0]),
        .pad_pu(),
        .pin_level(a_lvl[0])
    );
    ppfm_pin u_pa1 (
        .clk(SYS_CLK), .rst(RST),
        .alt_en(a_alt_en[1]),
        .alt_out(a_alt_out[1]),
        .alt_oe(a_alt_oe[1]),
        .gp_dir(PORT_A_DIRECTION[1]),
        .gp_out(PORT_A_OUTPUT[1]),
        .pu_en(1'b0),
        .pad_in(PA_PAD_IN[1]),
        .pad_out(PA_PAD_OUT[1]),
        .pad_oe(PA_PAD_OE[1]),
        .pad_pu(),
        .pin_level(a_lvl[1])
    );
    ppfm_pin u_pa2 (
        .clk(SYS_CLK), .rst(RST),
        .alt_en(a_alt_en[2]),
        .alt_out(a_alt_out[2]),
        .alt_oe(a_alt_oe[2]),
        .gp_dir(PORT_A_DIRECTION[2]),
        .gp_out(PORT_A_OUTPUT[2]),
        .pu_en(1'b0),
        .pad_in(PA_PAD_IN[2]),
        .pad_out(PA_PAD_OUT[2]),
        .pad_oe(PA_PAD_OE[2]),
        .pad_pu(),
        .pin_level(a_lvl[2])
    );
    ppfm_pin u_pa3 (
        .clk(SYS_CLK), .rst(RST),
        .alt_en(a_alt_en[3]),
        .alt_out(a_alt_out[3]),
        .alt_oe(a_alt_oe[3]),
        .gp_dir(PORT_A_DIRECTION[3]),
        .gp_out(PORT_A_OUTPUT[3]),
        .pu_en(1'b0),
        .pad_in(PA_PAD_IN[3]),
        .pad_out(PA_PAD_OUT[3]),
        .pad_oe(PA_PAD_OE[3]),
        .pad_pu(),
        .pin_level(a_lvl[3])
    );
    ppfm_pin u_pa4 (
        .clk(SYS_CLK), .rst(RST),
        .alt_en(a_alt_en[4]),
        .alt_out(a_alt_out[4]),
        .alt_oe(a_alt_oe[4]),
        .gp_dir(PORT_A_DIRECTION[4]),
        .gp_out(PORT_A_OUTPUT[4]),
        .pu_en(1'b0),
        .pad_in(PA_PAD_IN[4]),
        .pad_out(PA_PAD_OUT[4]),
        .pad_oe(PA_PAD_OE[4]),
        .pad_pu(),
        .pin_level(a_lvl[4])
    );
    ppfm_pin u_pa5 (
        .clk(SYS_CLK), .rst(RST),
        .alt_en(a_alt_en[5]),
        .alt_out(a_alt_out[5]),
        .alt_oe(a_alt_oe[5]),
        .gp_dir(PORT_A_DIRECTION[5]),
        .gp_out(PORT_A_OUTPUT[5]),
        .pu_en(1'b0),
        .pad_in(PA_PAD_IN[5]),
        .pad_out(PA_PAD_OUT[5]),
        .pad_oe(PA_PAD_OE[5]),
        .pad_pu(),
        .pin_level(a_lvl[5])
    );
    ppfm_pin u_pb0 (
        .clk(SYS_CLK), .rst(RST),
        .alt_en(b_alt_en[0]),
        .alt_out(b_alt_out[0]),
        .alt_oe(b_alt_oe[0]),
        .gp_dir(PORT_B_DIRECTION[0]),
        .gp_out(PORT_B_OUTPUT[0]),
        .pu_en(b_pu[0]),
        .pad_in(PB_PAD_IN[0]),
        .pad_out(PB_PAD_OUT[0]),
        .pad_oe(PB_PAD_OE[0]),
        .pad_pu(PB_PAD_PU[0]),
        .pin_level(b_lvl[0])
    );
    ppfm_pin u_pb1 (
        .clk(SYS_CLK), .rst(RST),
        .alt_en(b_alt_en[1]),
        .alt_out(b_alt_out[1]),
        .alt_oe(b_alt_oe[1]),
        .gp_dir(PORT_B_DIRECTION[1]),
        .gp_out(PORT_B_OUTPUT[1]),
        .pu_en(b_pu[1]),
        .pad_in(PB_PAD_IN[1]),
        .pad_out(PB_PAD_OUT[1]),
        .pad_oe(PB_PAD_OE[1]),
        .pad_pu(PB_PAD_PU[1]),
        .pin_level(b_lvl[1])
    );
    ppfm_pin u_pb2 (
        .clk(SYS_CLK), .rst(RST),
        .alt_en(b_alt_en[2]),
        .alt_out(b_alt_out[2]),
        .alt_oe(b_alt_oe[2]),
        .gp_dir(PORT_B_DIRECTION[2]),
        .gp_out(PORT_B_OUTPUT[2]),
        .pu_en(b_pu[2]),
        .pad_in(PB_PAD_IN[2]),
        .pad_out(PB_PAD_OUT[2]),
        .pad_oe(PB_PAD_OE[2]),
        .pad_pu(PB_PAD_PU[2]),
        .pin_level(b_lvl[2])
    );
    ppfm_pin u_pb3 (
        .clk(SYS_CLK), .rst(RST),
        .alt_en(b_alt_en[3]),
        .alt_out(b_alt_out[3]),
        .alt_oe(b_alt_oe[3]),
        .gp_dir(PORT_B_DIRECTION[3]),
        .gp_out(PORT_B_OUTPUT[3]),
        .pu_en(b_pu[3]),
        .pad_in(PB_PAD_IN[3]),
        .pad_out(PB_PAD_OUT[3]),
        .pad_oe(PB_PAD_OE[3]),
        .pad_pu(PB_PAD_PU[3]),
        .pin_level(b_lvl[3])
    );

    always @(posedge SYS_CLK) begin
        if (RST) begin
            PORT_A_INPUT <= 6'h00;
            PORT_B_INPUT <= 4'h0;
        end else begin
            PORT_A_INPUT <= a_lvl;
            PORT_B_INPUT <= b_lvl;
        end
    end

    // Serial receive, SPI select, two-wire, TDI and TMS inputs idle high when their pin is not selected; MOSI, SCLK, timer, irq and TCK idle low
    assign SERIAL_RECEIVE_LINE = (s0 == `PPFM_SEL_ALT1) ? a_lvl[0] : 1'b1;
    assign SPI_MOSI_IN = (s0 == `PPFM_SEL_ALT2) ? a_lvl[0] : 1'b0;
    assign SPI_SCLK_IN = (s2 == `PPFM_SEL_ALT2) ? a_lvl[2] : 1'b0;
    assign SPI_SSEL_IN = (s3 == `PPFM_SEL_ALT2) ? a_lvl[3] : 1'b1;
    assign TWOWIRE_A_CLOCK = (s2 == `PPFM_SEL_ALT1) ? a_lvl[2] : 1'b1;
    assign TWOWIRE_A_DATA = (s3 == `PPFM_SEL_ALT1) ? a_lvl[3] : 1'b1;
    assign TIMER_B_CHANNEL_A_IN = (s4 == `PPFM_SEL_ALT1) ? a_lvl[4] : 1'b0;
    assign TIMER_B_CHANNEL_B_IN = (s5 == `PPFM_SEL_ALT1) ? a_lvl[5] : 1'b0;
    assign EXT_IRQ_LINES[0] = (s0 == `PPFM_SEL_ALT3) & a_lvl[0];
    assign EXT_IRQ_LINES[1] = (s1 == `PPFM_SEL_ALT3) & a_lvl[1];
    assign EXT_IRQ_LINES[2] = (s2 == `PPFM_SEL_ALT3) & a_lvl[2];
    assign EXT_IRQ_LINES[3] = (s3 == `PPFM_SEL_ALT3) & a_lvl[3];
    assign EXT_IRQ_LINES[4] = (s4 != `PPFM_SEL_GPIO) &
                              (s4 != `PPFM_SEL_ALT1) & a_lvl[4];
    assign EXT_IRQ_LINES[5] = (s5 != `PPFM_SEL_GPIO) &
                              (s5 != `PPFM_SEL_ALT1) & a_lvl[5];
    assign TWOWIRE_B_CLOCK = tw_b ? b_lvl[`PPFM_PB_TCK] : 1'b1;
    assign TWOWIRE_B_DATA = tw_b ? b_lvl[`PPFM_PB_TDI] : 1'b1;
    assign TAP_TCK = tap_en_r ? b_lvl[`PPFM_PB_TCK] : 1'b0;
    assign TAP_TDI = tap_en_r ? b_lvl[`PPFM_PB_TDI] : 1'b1;
    assign TAP_TMS = tap_en_r ? b_lvl[`PPFM_PB_TMS] : 1'b1;
endmodule
`default_nettype wire

// File: ppfm_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module ppfm_assertions (
    input wire logic SYS_CLK,
    input wire logic RST,
    input wire logic [5:0] PORT_A_DIRECTION,
    input wire logic [5:0] PORT_A_OUTPUT,
    input wire logic [11:0] PORT_A_SEL,
    input wire logic [5:0] PA_PAD_OUT,
    input wire logic [5:0] PA_PAD_OE,
    input wire logic [5:0] EXT_IRQ_LINES,
    input wire logic SERIAL_TRANSMIT_LINE,
    input wire logic [3:0] PORT_B_DIRECTION,
    input wire logic [3:0] PORT_B_OUTPUT,
    input wire logic [3:0] PB_PAD_OUT,
    input wire logic [3:0] PB_PAD_OE,
    input wire logic [3:0] PB_PAD_PU,
    input wire logic TAP_ENABLE_WR,
    input wire logic TAP_ENABLE_VAL,
    input wire logic SYSTEM_CONTROL_TAP,
    input wire logic TWOWIRE_B_EN,
    input wire logic TAP_SHIFT_IR,
    input wire logic TAP_SHIFT_DR
);
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (RST);
    sequence s_tap_off;
        TAP_ENABLE_WR && !TAP_ENABLE_VAL ##1 !SYSTEM_CONTROL_TAP;
    endsequence
    AST_PA_HIZ: assert property ($fell(RST) |-> PA_PAD_OE == 6'h0)
        else $error("Port A driven after reset");
    AST_PA_GPIO: assert property (PORT_A_SEL[1:0] == 2'h0 |=>
        PA_PAD_OE[0] == $past(PORT_A_DIRECTION[0]) &&
        PA_PAD_OUT[0] == $past(PORT_A_OUTPUT[0])) else $error("Pin 0 gpio");
    AST_PA_TX: assert property (PORT_A_SEL[3:2] == 2'h1 |=>
        PA_PAD_OE[1] && PA_PAD_OUT[1] == $past(SERIAL_TRANSMIT_LINE))
        else $error("Pin 1 transmit");
    AST_PA_IRQ_F: assert property (PORT_A_SEL[11:10] >= 2'h2 |=>
        !PA_PAD_OE[5]) else $error("Pin 5 irq driven");
    AST_IRQ_IDLE: assert property (PORT_A_SEL[1:0] != 2'h3 |->
        !EXT_IRQ_LINES[0]) else $error("Irq a without enable");
    AST_TDO_SHIFT: assert property (SYSTEM_CONTROL_TAP |=>
        PB_PAD_OE[3] == ($past(TAP_SHIFT_IR) || $past(TAP_SHIFT_DR)))
        else $error("Test out enable");
    AST_TAP_WRITE: assert property (TAP_ENABLE_WR |=>
        SYSTEM_CONTROL_TAP == $past(TAP_ENABLE_VAL)) else $error("Tap bit");
    AST_TAP_RELEASE: assert property (s_tap_off |=> PB_PAD_PU == 4'h0)
        else $error("Pullups kept");
    AST_PB_GPIO: assert property (!SYSTEM_CONTROL_TAP && !TWOWIRE_B_EN |=>
        PB_PAD_OE == $past(PORT_B_DIRECTION) &&
        PB_PAD_OUT == $past(PORT_B_OUTPUT)) else $error("Port B gpio");
endmodule
bind ppfm_top ppfm_assertions u_chk (.SYS_CLK, .RST, .PORT_A_DIRECTION,
    .PORT_A_OUTPUT, .PORT_A_SEL, .PA_PAD_OUT, .PA_PAD_OE, .EXT_IRQ_LINES,
    .SERIAL_TRANSMIT_LINE, .PORT_B_DIRECTION, .PORT_B_OUTPUT, .PB_PAD_OUT,
    .PB_PAD_OE, .PB_PAD_PU, .TAP_ENABLE_WR, .TAP_ENABLE_VAL,
    .SYSTEM_CONTROL_TAP, .TWOWIRE_B_EN, .TAP_SHIFT_IR, .TAP_SHIFT_DR);
`default_nettype wire

// File: ppfm_pads.sv
`timescale 1ns/1ps
`default_nettype none
module ppfm_pads #(parameter int W = 6) (
    input wire logic clk,
    input wire logic [W-1:0] pad_out,
    input wire logic [W-1:0] pad_oe,
    input wire logic [W-1:0] pad_pu,
    input wire logic [W-1:0] ext_val,
    input wire logic [W-1:0] ext_en,
    output wire logic [W-1:0] pad_in
);
    logic [W-1:0] last_r = '0;
    wire logic [W-1:0] held = pad_oe | ext_en;
    // Released pins go to the pullup, else to the inverse of the last level
    assign pad_in = (pad_oe & pad_out) | (~pad_oe & ext_en & ext_val) |
        (~held & (pad_pu | ~last_r));
    always @(posedge clk) begin
        last_r <= (held & pad_in) | (~held & last_r);
    end
endmodule
`default_nettype wire

// File: tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic SYS_CLK, RST, TAP_ENABLE_WR, TAP_ENABLE_VAL, TWOWIRE_B_EN, TAP_TDO;
    logic SERIAL_TRANSMIT_LINE, SPI_MISO_OUT, SPI_MISO_OE, TAP_SHIFT_IR;
    logic TWOWIRE_A_CLOCK_LOW, TWOWIRE_A_DATA_LOW, TWOWIRE_B_CLOCK_LOW;
    logic TWOWIRE_B_DATA_LOW, TAP_SHIFT_DR, TIMER_B_CHANNEL_A_OUT;
    logic TIMER_B_CHANNEL_A_OE, TIMER_B_CHANNEL_B_OUT, TIMER_B_CHANNEL_B_OE;
    logic [5:0] PORT_A_DIRECTION, PORT_A_OUTPUT, ext_a_val, ext_a_en;
    logic [11:0] PORT_A_SEL;
    logic [3:0] PORT_B_DIRECTION, PORT_B_OUTPUT, ext_b_val, ext_b_en;
    wire logic [5:0] PORT_A_INPUT, PA_PAD_OUT, PA_PAD_OE, EXT_IRQ_LINES;
    wire logic [5:0] PA_PAD_IN;
    wire logic [3:0] PORT_B_INPUT, PB_PAD_OUT, PB_PAD_OE, PB_PAD_PU, PB_PAD_IN;
    wire logic SYSTEM_CONTROL_TAP, SERIAL_RECEIVE_LINE, SPI_MOSI_IN;
    wire logic SPI_SCLK_IN, SPI_SSEL_IN, TWOWIRE_A_CLOCK, TWOWIRE_A_DATA;
    wire logic TWOWIRE_B_CLOCK, TWOWIRE_B_DATA, TIMER_B_CHANNEL_A_IN;
    wire logic TIMER_B_CHANNEL_B_IN, TAP_TCK, TAP_TDI, TAP_TMS;
    int failures = 0;
    int n_compared = 0;
    ppfm_top uut (.SYS_CLK(SYS_CLK), .RST(RST),
        .PORT_A_DIRECTION(PORT_A_DIRECTION), .PORT_A_OUTPUT(PORT_A_OUTPUT),
        .PORT_A_INPUT(PORT_A_INPUT), .PORT_A_SEL(PORT_A_SEL),
        .PORT_B_DIRECTION(PORT_B_DIRECTION), .PORT_B_OUTPUT(PORT_B_OUTPUT),
        .PORT_B_INPUT(PORT_B_INPUT), .TAP_ENABLE_WR(TAP_ENABLE_WR),
        .TAP_ENABLE_VAL(TAP_ENABLE_VAL),
        .SYSTEM_CONTROL_TAP(SYSTEM_CONTROL_TAP), .TWOWIRE_B_EN(TWOWIRE_B_EN),
        .PA_PAD_IN(PA_PAD_IN), .PA_PAD_OUT(PA_PAD_OUT), .PA_PAD_OE(PA_PAD_OE),
        .PB_PAD_IN(PB_PAD_IN), .PB_PAD_OUT(PB_PAD_OUT), .PB_PAD_OE(PB_PAD_OE),
        .PB_PAD_PU(PB_PAD_PU), .SERIAL_RECEIVE_LINE(SERIAL_RECEIVE_LINE),
        .SERIAL_TRANSMIT_LINE(SERIAL_TRANSMIT_LINE),
        .SPI_MISO_OUT(SPI_MISO_OUT), .SPI_MISO_OE(SPI_MISO_OE),
        .SPI_MOSI_IN(SPI_MOSI_IN), .SPI_SCLK_IN(SPI_SCLK_IN),
        .SPI_SSEL_IN(SPI_SSEL_IN),
        .TWOWIRE_A_CLOCK_LOW(TWOWIRE_A_CLOCK_LOW),
        .TWOWIRE_A_DATA_LOW(TWOWIRE_A_DATA_LOW),
        .TWOWIRE_A_CLOCK(TWOWIRE_A_CLOCK), .TWOWIRE_A_DATA(TWOWIRE_A_DATA),
        .TWOWIRE_B_CLOCK_LOW(TWOWIRE_B_CLOCK_LOW),
        .TWOWIRE_B_DATA_LOW(TWOWIRE_B_DATA_LOW),
        .TWOWIRE_B_CLOCK(TWOWIRE_B_CLOCK), .TWOWIRE_B_DATA(TWOWIRE_B_DATA),
        .TIMER_B_CHANNEL_A_OUT(TIMER_B_CHANNEL_A_OUT),
        .TIMER_B_CHANNEL_A_OE(TIMER_B_CHANNEL_A_OE),
        .TIMER_B_CHANNEL_A_IN(TIMER_B_CHANNEL_A_IN),
        .TIMER_B_CHANNEL_B_OUT(TIMER_B_CHANNEL_B_OUT),
        .TIMER_B_CHANNEL_B_OE(TIMER_B_CHANNEL_B_OE),
        .TIMER_B_CHANNEL_B_IN(TIMER_B_CHANNEL_B_IN),
        .EXT_IRQ_LINES(EXT_IRQ_LINES), .TAP_TCK(TAP_TCK), .TAP_TDI(TAP_TDI),
        .TAP_TMS(TAP_TMS), .TAP_TDO(TAP_TDO), .TAP_SHIFT_IR(TAP_SHIFT_IR),
        .TAP_SHIFT_DR(TAP_SHIFT_DR));
    ppfm_pads #(.W(6)) pads_a (.clk(SYS_CLK), .pad_out(PA_PAD_OUT),
        .pad_oe(PA_PAD_OE), .pad_pu(6'h0), .ext_val(ext_a_val),
        .ext_en(ext_a_en), .pad_in(PA_PAD_IN));
    ppfm_pads #(.W(4)) pads_b (.clk(SYS_CLK), .pad_out(PB_PAD_OUT),
        .pad_oe(PB_PAD_OE), .pad_pu(PB_PAD_PU), .ext_val(ext_b_val),
        .ext_en(ext_b_en), .pad_in(PB_PAD_IN));
    initial begin
        SYS_CLK = 0;
        forever #4 SYS_CLK = ~SYS_CLK;
    end
    task step(input int n);
        repeat (n) @(negedge SYS_CLK);
    endtask
    task chk(input logic [11:0] got, input logic [11:0] exp);
        n_compared++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task give_verdict;
        if (failures == 0 && n_compared > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task apply_a(input logic [11:0] sel, input logic [5:0] val, exp_in);
        int i;
        PORT_A_SEL = sel;
        ext_a_val = val;
        for (i = 0; i < 12 && PORT_A_INPUT !== exp_in; i++) step(1);
        chk(PORT_A_INPUT, exp_in);
        if (i == 12) give_verdict;
    endtask
    task t_reset;
        chk(PA_PAD_OE, 6'h0);
        chk({SYSTEM_CONTROL_TAP, PB_PAD_PU}, 5'h1f);
        chk(PB_PAD_OE[3], 1'h0);
    endtask
    task t_gpio_a;
        PORT_A_DIRECTION = 6'h2a;
        PORT_A_OUTPUT = 6'h0f;
        ext_a_en = 6'h15;
        apply_a(12'h000, 6'h11, 6'h1b);
        chk(PA_PAD_OE, 6'h2a);
        chk(PA_PAD_OUT & PA_PAD_OE, 6'h0a);
    endtask
    task t_alt_a;
        PORT_A_DIRECTION = 6'h0;
        ext_a_en = 6'h3f;
        SERIAL_TRANSMIT_LINE = 1;
        {TIMER_B_CHANNEL_A_OE, TIMER_B_CHANNEL_A_OUT} = 2'h3;
        apply_a(12'h555, 6'h30, 6'h32);
        chk({SERIAL_RECEIVE_LINE, TWOWIRE_A_DATA}, 2'h0);
        chk(TWOWIRE_A_CLOCK, 1'h0);
        chk({TIMER_B_CHANNEL_A_IN, TIMER_B_CHANNEL_B_IN}, 2'h3);
        chk({PA_PAD_OE[4], PA_PAD_OE[1], EXT_IRQ_LINES}, 8'hc0);
        TWOWIRE_A_CLOCK_LOW = 1;
        step(2);
        chk({PA_PAD_OE[2], PA_PAD_OUT[2]}, 2'h2);
        {SPI_MISO_OE, SPI_MISO_OUT} = 2'h2;
        apply_a(12'haaa, 6'h35, 6'h35);
        chk({SPI_MOSI_IN, SPI_SCLK_IN, SPI_SSEL_IN}, 3'h6);
        chk({PA_PAD_OE[1], EXT_IRQ_LINES}, 7'h70);
        apply_a(12'hfff, 6'h2b, 6'h2b);
        chk({PA_PAD_OE, EXT_IRQ_LINES}, 12'h02b);
        PORT_A_DIRECTION = 6'h3f;
        PORT_A_OUTPUT = 6'h15;
        PORT_A_SEL = 12'h0;
        step(2);
        chk({PA_PAD_OE, PA_PAD_OUT}, 12'hfd5);
    endtask
    task t_tap;
        PORT_B_DIRECTION = 4'hf;
        {ext_b_en, ext_b_val} = 8'h72;
        {TAP_SHIFT_IR, TAP_TDO} = 2'h3;
        step(6);
        chk({TAP_TCK, TAP_TDI, TAP_TMS}, 3'h2);
        chk(PORT_B_INPUT, 4'ha);
        chk({PB_PAD_OE, PB_PAD_OUT[3]}, 5'h11);
        {TAP_SHIFT_IR, TAP_SHIFT_DR, TAP_TDO} = 3'h2;
        step(2);
        chk({PB_PAD_OE[3], PB_PAD_OUT[3]}, 2'h2);
        TAP_SHIFT_DR = 0;
        {TAP_ENABLE_WR, TAP_ENABLE_VAL} = 2'h2;
        step(1);
        chk(PB_PAD_OE[3], 1'h0);
        TAP_ENABLE_WR = 0;
        step(2);
        chk({SYSTEM_CONTROL_TAP, PB_PAD_PU}, 5'h0);
        chk({PB_PAD_OE, PB_PAD_OUT}, 8'hf0);
        {PORT_B_DIRECTION, TWOWIRE_B_EN, TWOWIRE_B_CLOCK_LOW} = 6'h3;
        {ext_b_en, ext_b_val} = 8'h20;
        step(6);
        chk({PB_PAD_OE[1:0], PB_PAD_OUT[0], TWOWIRE_B_DATA}, 4'h4);
        chk(TWOWIRE_B_CLOCK, 1'h0);
    endtask
    initial begin
        RST = 1;
        {TAP_ENABLE_WR, TAP_ENABLE_VAL, TWOWIRE_B_EN, TAP_TDO, TAP_SHIFT_IR} = '0;
        {SERIAL_TRANSMIT_LINE, SPI_MISO_OUT, SPI_MISO_OE, TAP_SHIFT_DR} = '0;
        {TWOWIRE_A_CLOCK_LOW, TWOWIRE_A_DATA_LOW, TWOWIRE_B_CLOCK_LOW} = '0;
        {TWOWIRE_B_DATA_LOW, TIMER_B_CHANNEL_A_OUT, TIMER_B_CHANNEL_A_OE} = '0;
        {TIMER_B_CHANNEL_B_OUT, TIMER_B_CHANNEL_B_OE, PORT_A_SEL} = '0;
        {PORT_A_DIRECTION, PORT_A_OUTPUT, ext_a_val, ext_a_en} = '0;
        {PORT_B_DIRECTION, PORT_B_OUTPUT, ext_b_val, ext_b_en} = '0;
        step(6);
        chk(PB_PAD_PU, 4'hf);
        RST = 0;
        step(2);
        t_reset;
        t_gpio_a;
        t_alt_a;
        t_tap;
        give_verdict;
    end
    initial begin
        #200000;
        failures++;
        give_verdict;
    end
endmodule
`default_nettype wire
